// ---- hw/cpu_entry_pkg.sv ----
// Purpose: Shared constants and types for the reset/interrupt entry core.
// Assumes: 8-bit data, 16-bit addresses, one bus cycle per clock.
// Notes: Vector placement for hardware requests is a local choice.
`default_nettype none

package cpu_entry_pkg;

  // ------------------------------------------------------------
  // Vectors and reset values
  // ------------------------------------------------------------
  localparam logic [15:0] RESET_VEC = 16'hfffe;
  localparam logic [15:0] TRAP_VEC = 16'hfffc;
  localparam logic [15:0] IRQ_VEC_BASE = 16'hfffa;
  localparam logic [15:0] SP_RESET = 16'h00ff;
  localparam logic [7:0] CCR_RESET = 8'h68;
  localparam logic [15:0] PC_RESET = 16'h0000;

  // ------------------------------------------------------------
  // Condition code bit positions
  // ------------------------------------------------------------
  localparam int CCR_V = 7;
  localparam int CCR_H = 4;
  localparam int CCR_I = 3;
  localparam int CCR_N = 2;
  localparam int CCR_Z = 1;
  localparam int CCR_C = 0;

  // ------------------------------------------------------------
  // Opcodes and opcode fields
  // ------------------------------------------------------------
  localparam logic [7:0] OPC_PREFIX = 8'h9e;
  localparam logic [7:0] OPC_TRAP = 8'h83;
  localparam logic [7:0] OPC_SP_ADD = 8'ha7;
  localparam logic [7:0] OPC_HX_ADD = 8'haf;
  localparam logic [3:0] LO_ADC = 4'h9;
  localparam logic [3:0] LO_ADD = 4'hb;
  localparam logic [3:0] HI_IMM = 4'ha;
  localparam logic [3:0] HI_DIR = 4'hb;
  localparam logic [3:0] HI_EXT = 4'hc;
  localparam logic [3:0] HI_IX2 = 4'hd;
  localparam logic [3:0] HI_IX1 = 4'he;
  localparam logic [3:0] HI_IX = 4'hf;
  localparam int OPC_SINGLE_COUNT = 254;
  localparam int OPC_PREFIXED_COUNT = 47;

  // ------------------------------------------------------------
  // Cycle counts, request limit and id width
  // ------------------------------------------------------------
  localparam logic [2:0] CYC_IMM = 3'h2;
  localparam logic [2:0] CYC_DIR = 3'h3;
  localparam logic [2:0] CYC_EXT = 3'h4;
  localparam logic [2:0] CYC_IX2 = 3'h4;
  localparam logic [2:0] CYC_IX1 = 3'h3;
  localparam logic [2:0] CYC_IX = 3'h3;
  localparam logic [2:0] CYC_SP2 = 3'h5;
  localparam logic [2:0] CYC_SP1 = 3'h4;
  localparam logic [2:0] CYC_OTHER = 3'h1;
  localparam logic [2:0] FILL_LAST = 3'h2;
  localparam logic [2:0] STACK_LAST = 3'h4;
  localparam int IRQ_MAX = 16;
  localparam int IRQ_ID_W = 4;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    M_NONE, M_IMM, M_DIR, M_EXT, M_IX2, M_IX1, M_IX, M_SP2, M_SP1
  } addr_mode_type;

  typedef enum logic [2:0] {
    K_OTHER, K_ADC, K_ADD, K_SP_ADD, K_HX_ADD, K_TRAP
  } op_kind_type;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } bus_req_type;

  typedef struct packed {
    logic v;
    logic h;
    logic n;
    logic z;
    logic c;
  } alu_flags_type;

endpackage : cpu_entry_pkg

`default_nettype wire

// ---- hw/cpu_pin_sync.sv ----
// Purpose: Two-flop synchroniser for asynchronous pins.
// Assumes: Inputs are quasi-static levels.
// Notes: First stage feeds only the second stage.
`default_nettype none

module cpu_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk, // Core clock
  input wire logic i_rst, // Synchronous reset
  input wire logic [W-1:0] i_d, // Asynchronous levels
  output logic [W-1:0] o_q // Synchronised levels
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // Stage shift
  always_comb begin
    meta_nxt = i_d;
    q_nxt = meta_r;
  end

  // Register both stages
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_r <= RST_VAL;
      q_r <= RST_VAL;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign o_q = q_r;

endmodule : cpu_pin_sync

`default_nettype wire

// ---- hw/cpu_add8.sv ----
// Purpose: 8-bit adder with condition flags for the add instructions.
// Assumes: Purely combinational, used once per cycle.
// Notes: Half carry is the carry out of bit 3.
`default_nettype none

module cpu_add8 (
  input wire logic [7:0] i_a, // Accumulator
  input wire logic [7:0] i_m, // Operand
  input wire logic i_cin, // Carry in
  output logic [7:0] o_sum, // Result
  output cpu_entry_pkg::alu_flags_type o_flags // V H N Z C
);

  logic [8:0] full;
  logic [4:0] low;

  // Sum and flags
  always_comb begin
    full = {1'b0, i_a} + {1'b0, i_m} + {8'h00, i_cin};
    low = {1'b0, i_a[3:0]} + {1'b0, i_m[3:0]} + {4'h0, i_cin};
    o_sum = full[7:0];
    o_flags.v = (i_a[7] & i_m[7] & ~full[7]) | (~i_a[7] & ~i_m[7] & full[7]);
    o_flags.h = low[4];
    o_flags.n = full[7];
    o_flags.z = (full[7:0] == 8'h00);
    o_flags.c = full[8];
  end

endmodule : cpu_add8

`default_nettype wire

// ---- hw/cpu_reset_interrupt_entry.sv ----
// Purpose: Reset entry, interrupt/trap entry and add-class execution of an 8-bit core.
// Assumes: Memory answers a read within the same bus cycle (i_rdata sampled at its end).
// Notes: Opcodes outside the add group, except the trap and the prefix, run as one-cycle no-ops.
`default_nettype none

module cpu_reset_interrupt_entry #(
  parameter int IRQ_COUNT = 8
) (
  input wire logic i_clk, // Core clock, 200 MHz
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic i_por_pin, // Power-on event, asynchronous, high
  input wire logic i_reset_pin_n, // External reset pin, asynchronous, low
  input wire logic i_wdog_timeout, // Watchdog timeout, same clock
  input wire logic i_int_src_done, // Internal source check complete
  input wire logic [IRQ_COUNT-1:0] i_irq_pending, // Requests, bit 0 highest
  input wire logic [7:0] i_rdata, // Read data of current bus cycle
  output cpu_entry_pkg::bus_req_type o_bus, // Current bus cycle
  output logic o_irq_ack, // Pulse when a request is vectored
  output logic [cpu_entry_pkg::IRQ_ID_W-1:0] o_irq_ack_id, // Acknowledged request
  output logic o_in_reset, // Reset event in progress
  output logic [7:0] o_acc, // Accumulator
  output logic [15:0] o_index_pair, // Index pair
  output logic [15:0] o_stack_ptr, // Stack pointer
  output logic [7:0] o_ccr, // Condition code register
  output logic [15:0] o_prog_ctr // Program counter
);

  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  if (IRQ_COUNT < 1 || IRQ_COUNT > cpu_entry_pkg::IRQ_MAX) begin : g_bad_count
    $error("IRQ_COUNT out of range");
  end

  typedef enum logic [3:0] {
    ST_HOLD, ST_VEC_HI, ST_VEC_LO, ST_FREE, ST_FILL,
    ST_OP, ST_OP2, ST_OPND, ST_MEM, ST_PAD, ST_STACK
  } state_type;

  // ------------------------------------------------------------
  // Pin synchronisers and reset collection
  // ------------------------------------------------------------
  logic [1:0] pins_s;
  logic rst_evt;

  // Reset pin syncs to asserted so the core holds until the pin is seen high
  cpu_pin_sync #(.W(2), .RST_VAL(2'b01)) u_pin_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d({i_reset_pin_n, i_por_pin}),
    .o_q(pins_s)
  );

  // Any source holds reset; release needs source check done and pin high
  assign rst_evt = pins_s[0] | i_wdog_timeout | ~pins_s[1] | ~i_int_src_done;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  state_type st_r, st_nxt;
  logic [2:0] cyc_r, cyc_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [15:0] sp_r, sp_nxt;
  logic [15:0] hx_r, hx_nxt;
  logic [7:0] a_r, a_nxt;
  logic [7:0] ccr_r, ccr_nxt;
  logic [15:0] vec_r, vec_nxt;
  logic [7:0] q_r, q_nxt;
  logic q_valid_r, q_valid_nxt;
  logic [7:0] hi_r, hi_nxt;
  cpu_entry_pkg::addr_mode_type mode_r, mode_nxt;
  cpu_entry_pkg::op_kind_type kind_r, kind_nxt;
  cpu_entry_pkg::bus_req_type bus_r, bus_nxt;
  logic ack_r, ack_nxt;
  logic [cpu_entry_pkg::IRQ_ID_W-1:0] ack_id_r, ack_id_nxt;
  logic in_rst_r, in_rst_nxt;

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  // Only the add group and the trap are modelled; the full opcode map has
  // OPC_SINGLE_COUNT plain and OPC_PREFIXED_COUNT prefixed codes
  function automatic cpu_entry_pkg::op_kind_type kind_of(input logic [7:0] opc);
    if (opc == cpu_entry_pkg::OPC_TRAP) begin
      kind_of = cpu_entry_pkg::K_TRAP;
    end else if (opc == cpu_entry_pkg::OPC_SP_ADD) begin
      kind_of = cpu_entry_pkg::K_SP_ADD;
    end else if (opc == cpu_entry_pkg::OPC_HX_ADD) begin
      kind_of = cpu_entry_pkg::K_HX_ADD;
    end else if (opc[3:0] == cpu_entry_pkg::LO_ADC && opc[7:4] >= cpu_entry_pkg::HI_IMM) begin
      kind_of = cpu_entry_pkg::K_ADC;
    end else if (opc[3:0] == cpu_entry_pkg::LO_ADD && opc[7:4] >= cpu_entry_pkg::HI_IMM) begin
      kind_of = cpu_entry_pkg::K_ADD;
    end else begin
      kind_of = cpu_entry_pkg::K_OTHER;
    end
  endfunction : kind_of

  // Addressing mode from the high nibble; prefix selects stack-offset forms
  function automatic cpu_entry_pkg::addr_mode_type mode_of(input logic pre,
                                                           input logic [7:0] opc);
    mode_of = cpu_entry_pkg::M_NONE;
    if (pre) begin
      if (opc[7:4] == cpu_entry_pkg::HI_IX2) begin
        mode_of = cpu_entry_pkg::M_SP2;
      end else if (opc[7:4] == cpu_entry_pkg::HI_IX1) begin
        mode_of = cpu_entry_pkg::M_SP1;
      end
    end else begin
      case (opc[7:4])
        cpu_entry_pkg::HI_IMM: mode_of = cpu_entry_pkg::M_IMM;
        cpu_entry_pkg::HI_DIR: mode_of = cpu_entry_pkg::M_DIR;
        cpu_entry_pkg::HI_EXT: mode_of = cpu_entry_pkg::M_EXT;
        cpu_entry_pkg::HI_IX2: mode_of = cpu_entry_pkg::M_IX2;
        cpu_entry_pkg::HI_IX1: mode_of = cpu_entry_pkg::M_IX1;
        cpu_entry_pkg::HI_IX: mode_of = cpu_entry_pkg::M_IX;
        default: mode_of = cpu_entry_pkg::M_NONE;
      endcase
    end
  endfunction : mode_of

  // Bus cycles per addressing mode
  function automatic logic [2:0] cycles_of(input cpu_entry_pkg::addr_mode_type m);
    case (m)
      cpu_entry_pkg::M_IMM: cycles_of = cpu_entry_pkg::CYC_IMM;
      cpu_entry_pkg::M_DIR: cycles_of = cpu_entry_pkg::CYC_DIR;
      cpu_entry_pkg::M_EXT: cycles_of = cpu_entry_pkg::CYC_EXT;
      cpu_entry_pkg::M_IX2: cycles_of = cpu_entry_pkg::CYC_IX2;
      cpu_entry_pkg::M_IX1: cycles_of = cpu_entry_pkg::CYC_IX1;
      cpu_entry_pkg::M_IX: cycles_of = cpu_entry_pkg::CYC_IX;
      cpu_entry_pkg::M_SP2: cycles_of = cpu_entry_pkg::CYC_SP2;
      cpu_entry_pkg::M_SP1: cycles_of = cpu_entry_pkg::CYC_SP1;
      default: cycles_of = cpu_entry_pkg::CYC_OTHER;
    endcase
  endfunction : cycles_of

  // ------------------------------------------------------------
  // Adder
  // ------------------------------------------------------------
  logic [7:0] sum;
  cpu_entry_pkg::alu_flags_type flags;

  // Carry feeds only the carry form
  cpu_add8 u_add8 (
    .i_a(a_r),
    .i_m(i_rdata),
    .i_cin((kind_r == cpu_entry_pkg::K_ADC) & ccr_r[cpu_entry_pkg::CCR_C]),
    .o_sum(sum),
    .o_flags(flags)
  );

  // ------------------------------------------------------------
  // Sequencer next state
  // ------------------------------------------------------------
  logic boundary;
  logic take_trap;
  logic take_irq;
  logic executed;
  logic [7:0] opc;
  logic [15:0] sext;
  logic [cpu_entry_pkg::IRQ_ID_W-1:0] prio;

  always_comb begin
    st_nxt = st_r;
    cyc_nxt = cyc_r;
    cnt_nxt = cnt_r;
    pc_nxt = pc_r;
    sp_nxt = sp_r;
    hx_nxt = hx_r;
    a_nxt = a_r;
    ccr_nxt = ccr_r;
    vec_nxt = vec_r;
    q_nxt = q_r;
    q_valid_nxt = q_valid_r;
    hi_nxt = hi_r;
    mode_nxt = mode_r;
    kind_nxt = kind_r;
    bus_nxt = '0;
    ack_nxt = 1'b0;
    ack_id_nxt = ack_id_r;
    boundary = 1'b0;
    take_trap = 1'b0;
    executed = 1'b0;
    opc = i_rdata;
    sext = {{8{i_rdata[7]}}, i_rdata};
    prio = '0;
    // Lowest index wins; sampled when the entry sequence starts
    for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
      if (i_irq_pending[i]) begin
        prio = cpu_entry_pkg::IRQ_ID_W'(i);
      end
    end
    case (st_r)
      ST_HOLD: begin
        vec_nxt = cpu_entry_pkg::RESET_VEC;
        st_nxt = ST_VEC_HI;
        bus_nxt = '{addr: cpu_entry_pkg::RESET_VEC, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
      end
      ST_VEC_HI: begin
        pc_nxt = {i_rdata, pc_r[7:0]};
        st_nxt = ST_VEC_LO;
        bus_nxt = '{addr: vec_r + 16'h0001, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
      end
      ST_VEC_LO: begin
        pc_nxt = {pc_r[15:8], i_rdata};
        st_nxt = ST_FREE;
      end
      ST_FREE: begin
        cnt_nxt = 3'h0;
        st_nxt = ST_FILL;
        bus_nxt = '{addr: pc_r, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
      end
      ST_FILL: begin
        // Three fetches; the first byte is kept as the next opcode
        if (cnt_r == 3'h0) begin
          q_nxt = i_rdata;
        end
        if (cnt_r == cpu_entry_pkg::FILL_LAST) begin
          q_valid_nxt = 1'b1;
          st_nxt = ST_OP;
          bus_nxt = '{addr: pc_r, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
        end else begin
          cnt_nxt = cnt_r + 3'h1;
          bus_nxt = '{addr: pc_r + {13'h0000, cnt_r + 3'h1}, rd: 1'b1, wr: 1'b0,
                      wdata: 8'h00};
        end
      end
      ST_OP, ST_OP2: begin
        // First opcode after a refill comes from the queue byte
        opc = (st_r == ST_OP && q_valid_r) ? q_r : i_rdata;
        q_valid_nxt = 1'b0;
        pc_nxt = pc_r + 16'h0001;
        cyc_nxt = (st_r == ST_OP) ? 3'h1 : cyc_r + 3'h1;
        kind_nxt = kind_of(opc);
        mode_nxt = mode_of(st_r == ST_OP2, opc);
        if (st_r == ST_OP && opc == cpu_entry_pkg::OPC_PREFIX) begin
          st_nxt = ST_OP2;
          bus_nxt = '{addr: pc_nxt, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
        end else if (kind_nxt == cpu_entry_pkg::K_TRAP) begin
          take_trap = 1'b1;
        end else if (kind_nxt == cpu_entry_pkg::K_OTHER || mode_nxt == cpu_entry_pkg::M_NONE) begin
          boundary = (cyc_nxt >= cycles_of(cpu_entry_pkg::M_NONE));
          st_nxt = ST_PAD;
        end else if (mode_nxt == cpu_entry_pkg::M_IX) begin
          st_nxt = ST_MEM;
          bus_nxt = '{addr: hx_r, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
        end else begin
          cnt_nxt = 3'h0;
          st_nxt = ST_OPND;
          bus_nxt = '{addr: pc_nxt, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
        end
      end
      ST_OPND: begin
        pc_nxt = pc_r + 16'h0001;
        cyc_nxt = cyc_r + 3'h1;
        hi_nxt = i_rdata;
        if (mode_r == cpu_entry_pkg::M_IMM) begin
          executed = 1'b1;
        end else if (cnt_r == 3'h0 && (mode_r == cpu_entry_pkg::M_EXT ||
                     mode_r == cpu_entry_pkg::M_IX2 || mode_r == cpu_entry_pkg::M_SP2)) begin
          cnt_nxt = 3'h1;
          bus_nxt = '{addr: pc_nxt, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
        end else begin
          st_nxt = ST_MEM;
          bus_nxt.rd = 1'b1;
          case (mode_r)
            cpu_entry_pkg::M_DIR: bus_nxt.addr = {8'h00, i_rdata};
            cpu_entry_pkg::M_EXT: bus_nxt.addr = {hi_r, i_rdata};
            cpu_entry_pkg::M_IX2: bus_nxt.addr = hx_r + {hi_r, i_rdata};
            cpu_entry_pkg::M_IX1: bus_nxt.addr = hx_r + {8'h00, i_rdata};
            cpu_entry_pkg::M_SP2: bus_nxt.addr = sp_r + {hi_r, i_rdata};
            default: bus_nxt.addr = sp_r + {8'h00, i_rdata};
          endcase
        end
      end
      ST_MEM: begin
        cyc_nxt = cyc_r + 3'h1;
        executed = 1'b1;
      end
      ST_PAD: begin
        cyc_nxt = cyc_r + 3'h1;
        boundary = (cyc_nxt >= cycles_of(mode_r));
      end
      ST_STACK: begin
        // Post-decrement stacking; upper index byte is deliberately skipped
        sp_nxt = sp_r - 16'h0001;
        if (cnt_r == cpu_entry_pkg::STACK_LAST) begin
          ccr_nxt[cpu_entry_pkg::CCR_I] = 1'b1;
          ack_nxt = (kind_r != cpu_entry_pkg::K_TRAP);
          st_nxt = ST_VEC_HI;
          bus_nxt = '{addr: vec_r, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
        end else begin
          cnt_nxt = cnt_r + 3'h1;
          bus_nxt.addr = sp_nxt;
          bus_nxt.wr = 1'b1;
          case (cnt_r)
            3'h0: bus_nxt.wdata = pc_r[15:8];
            3'h1: bus_nxt.wdata = hx_r[7:0];
            3'h2: bus_nxt.wdata = a_r;
            default: bus_nxt.wdata = ccr_r;
          endcase
        end
      end
      default: st_nxt = ST_HOLD;
    endcase

    // Data phase of an add-group instruction
    if (executed) begin
      case (kind_r)
        cpu_entry_pkg::K_ADC, cpu_entry_pkg::K_ADD: begin
          a_nxt = sum;
          ccr_nxt[cpu_entry_pkg::CCR_V] = flags.v;
          ccr_nxt[cpu_entry_pkg::CCR_H] = flags.h;
          ccr_nxt[cpu_entry_pkg::CCR_N] = flags.n;
          ccr_nxt[cpu_entry_pkg::CCR_Z] = flags.z;
          ccr_nxt[cpu_entry_pkg::CCR_C] = flags.c;
        end
        cpu_entry_pkg::K_SP_ADD: sp_nxt = sp_r + sext;
        cpu_entry_pkg::K_HX_ADD: hx_nxt = hx_r + sext;
        default: a_nxt = a_r;
      endcase
      st_nxt = ST_PAD;
      boundary = (cyc_nxt >= cycles_of(mode_r));
    end

    // Requests are honoured only between instructions, after pc moved on
    take_irq = boundary && (|i_irq_pending) && !ccr_nxt[cpu_entry_pkg::CCR_I];
    if (take_trap || take_irq) begin
      // Trap ignores the mask; first push is the return low byte
      vec_nxt = take_trap ? cpu_entry_pkg::TRAP_VEC
                          : cpu_entry_pkg::IRQ_VEC_BASE - {11'h000, prio, 1'b0};
      kind_nxt = take_trap ? cpu_entry_pkg::K_TRAP : cpu_entry_pkg::K_OTHER;
      ack_id_nxt = take_trap ? ack_id_r : prio;
      cnt_nxt = 3'h0;
      st_nxt = ST_STACK;
      bus_nxt = '{addr: sp_nxt, rd: 1'b0, wr: 1'b1, wdata: pc_nxt[7:0]};
    end else if (boundary) begin
      st_nxt = ST_OP;
      bus_nxt = '{addr: pc_nxt, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
    end

    // Reset aborts whatever cycle is running, with no boundary wait
    if (rst_evt) begin
      st_nxt = ST_HOLD;
      bus_nxt = '0;
      sp_nxt = cpu_entry_pkg::SP_RESET;
      ccr_nxt = cpu_entry_pkg::CCR_RESET;
      q_valid_nxt = 1'b0;
      ack_nxt = 1'b0;
    end
    in_rst_nxt = rst_evt;
  end

  // Register the sequencer
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= ST_HOLD;
      cyc_r <= 3'h0;
      cnt_r <= 3'h0;
      pc_r <= cpu_entry_pkg::PC_RESET;
      sp_r <= cpu_entry_pkg::SP_RESET;
      hx_r <= 16'h0000;
      a_r <= 8'h00;
      ccr_r <= cpu_entry_pkg::CCR_RESET;
      vec_r <= cpu_entry_pkg::RESET_VEC;
      q_r <= 8'h00;
      q_valid_r <= 1'b0;
      hi_r <= 8'h00;
      mode_r <= cpu_entry_pkg::M_NONE;
      kind_r <= cpu_entry_pkg::K_OTHER;
      bus_r <= '0;
      ack_r <= 1'b0;
      ack_id_r <= '0;
      in_rst_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cyc_r <= cyc_nxt;
      cnt_r <= cnt_nxt;
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
      hx_r <= hx_nxt;
      a_r <= a_nxt;
      ccr_r <= ccr_nxt;
      vec_r <= vec_nxt;
      q_r <= q_nxt;
      q_valid_r <= q_valid_nxt;
      hi_r <= hi_nxt;
      mode_r <= mode_nxt;
      kind_r <= kind_nxt;
      bus_r <= bus_nxt;
      ack_r <= ack_nxt;
      ack_id_r <= ack_id_nxt;
      in_rst_r <= in_rst_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs, all from flops
  // ------------------------------------------------------------
  assign o_bus = bus_r;
  assign o_irq_ack = ack_r;
  assign o_irq_ack_id = ack_id_r;
  assign o_in_reset = in_rst_r;
  assign o_acc = a_r;
  assign o_index_pair = hx_r;
  assign o_stack_ptr = sp_r;
  assign o_ccr = ccr_r;
  assign o_prog_ctr = pc_r;

endmodule : cpu_reset_interrupt_entry

`default_nettype wire

// ---- testbench/cpu_entry_checker.sv ----
// Purpose: Port assertions for the entry core.
// Assumes: One clock; i_rst synchronous, active high.
// Notes: The mask stays set in the bench, so the ack checks may stay idle.
`default_nettype none
module cpu_entry_checker (
  input wire logic i_clk, // Clock
  input wire logic i_rst, // Reset
  input wire logic i_wdog_timeout, // Watchdog
  input wire logic i_int_src_done, // Source check done
  input wire cpu_entry_pkg::bus_req_type o_bus, // Bus cycle
  input wire logic o_irq_ack, // Ack pulse
  input wire logic [cpu_entry_pkg::IRQ_ID_W-1:0] o_irq_ack_id, // Ack id
  input wire logic o_in_reset, // Reset flag
  input wire logic [7:0] o_ccr // Flags
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Entry steps
  sequence s_push;
    o_bus.wr && o_bus.addr == $past(o_bus.addr) - 16'h1;
  endsequence
  sequence s_fill;
    !o_bus.rd && !o_bus.wr ##1 o_bus.rd [*3];
  endsequence
  a_stack_order: assert property ($rose(o_bus.wr) |=> s_push [*4] ##1 o_bus.rd)
    else $error("stack order broken");
  a_reset_vec: assert property (o_bus.rd && o_bus.addr == 16'hfffe |=>
    o_bus.rd && o_bus.addr == 16'hffff)
    else $error("reset vector pair broken");
  a_free_fill: assert property (o_bus.rd && o_bus.addr inside {16'hffff, 16'hfffd} |=>
    s_fill)
    else $error("queue fill broken");
  a_wdog_abort: assert property (i_wdog_timeout |=> o_in_reset && !o_bus.rd && !o_bus.wr)
    else $error("watchdog did not abort");
  a_src_hold: assert property (!i_int_src_done |=> o_in_reset)
    else $error("reset ended early");
  a_ack_mask: assert property (o_irq_ack |=> o_ccr[cpu_entry_pkg::CCR_I])
    else $error("mask not set");
  a_ack_vector: assert property (o_irq_ack |->
    o_bus.rd && o_bus.addr == 16'hfffa - {11'h0, o_irq_ack_id, 1'b0})
    else $error("wrong vector");
  a_vec_low: assert property (o_irq_ack |=> o_bus.rd && o_bus.addr == $past(o_bus.addr) + 16'h1)
    else $error("vector low not next");
endmodule : cpu_entry_checker
bind cpu_reset_interrupt_entry cpu_entry_checker i_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_wdog_timeout(i_wdog_timeout), .i_int_src_done(i_int_src_done), .o_bus(o_bus),
  .o_irq_ack(o_irq_ack), .o_irq_ack_id(o_irq_ack_id), .o_in_reset(o_in_reset), .o_ccr(o_ccr));
`default_nettype wire

// ---- testbench/cpu_mem_model.sv ----
// Purpose: Zero-wait memory behind the core bus.
// Assumes: Reads answer within the bus cycle.
// Notes: Idle cycles show the inverse of the previous cycle's data, so back-to-back idle cycles alternate between it and the last byte.
`default_nettype none
module cpu_mem_model (
  input wire logic i_clk, // Clock
  input wire cpu_entry_pkg::bus_req_type i_bus, // Bus cycle
  output logic [7:0] o_rdata // Read data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [65536];
  logic [7:0] last_r = 8'h00;
  // Read path
  assign o_rdata = i_bus.rd ? mem[i_bus.addr] : ~last_r;
  // Writes land at the edge
  always @(posedge i_clk) begin
    last_r <= o_rdata;
    if (i_bus.wr) mem[i_bus.addr] <= i_bus.wdata;
  end
endmodule : cpu_mem_model
`default_nettype wire

// ---- testbench/tb_cpu_reset_interrupt_entry.sv ----
// Purpose: Reset sources, add group and trap entry.
// Assumes: Handler area holds undecoded one-cycle opcodes.
// Notes: Request 0 stays pending but the mask holds it off.
`default_nettype none
module tb_cpu_reset_interrupt_entry;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, por, pin_n, wdog, done, ack, in_rst;
  logic [7:0] irq, rdata, acc, condition_code_register;
  logic [3:0] ack_id;
  logic [15:0] hx, sp, pc;
  cpu_entry_pkg::bus_req_type bus;
  int err_total, comparisons, acks;
  cpu_reset_interrupt_entry i_dut (.i_clk(clk), .i_rst(rst), .i_por_pin(por),
    .i_reset_pin_n(pin_n), .i_wdog_timeout(wdog), .i_int_src_done(done),
    .i_irq_pending(irq), .i_rdata(rdata), .o_bus(bus), .o_irq_ack(ack),
    .o_irq_ack_id(ack_id), .o_in_reset(in_rst), .o_acc(acc), .o_index_pair(hx),
    .o_stack_ptr(sp), .o_ccr(condition_code_register), .o_prog_ctr(pc));
  cpu_mem_model i_mem (.i_clk(clk), .i_bus(bus), .o_rdata(rdata));
  // Clock and ack count
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (ack === 1'b1) acks <= acks + 1;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    if (err_total == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // Wait for the reset fetch, run the program, then judge state and stack
  task automatic run_program;
    logic [7:0] stk [5] = '{8'h09, 8'h01, 8'h10, 8'h00, 8'h7b};
    int n;
    logic [15:0] hx0;
    n = 0;
    for (int k = 0; k < 5; k++) i_mem.mem[16'h00f9 + k] = 8'h9d;
    while (!(bus.rd === 1'b1 && bus.addr === 16'hfffe) && n < 12) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(16'(n < 12), 16'h1);
    // A reset event leaves the index pair alone, so each run adds onto the last value
    hx0 = hx;
    stk[2] = 8'(hx0 + 16'h0010);
    repeat (60) @(posedge clk);
    #1;
    check({8'h00, acc}, 16'h0000);
    check({8'h00, condition_code_register}, 16'h007b);
    check(hx, hx0 + 16'h0010);
    check(sp, 16'h00f8);
    for (int k = 0; k < 5; k++) check({8'h00, i_mem.mem[16'h00fd - k]}, {8'h00, stk[k]});
    check(16'(acks), 16'h0);
  endtask : run_program
  // Main sequence; handler leaves upper index and mask alone
  initial begin
    logic [7:0] prog [9] = '{8'ha9, 8'h05, 8'hab, 8'hfb, 8'ha7, 8'hfe, 8'haf, 8'h10, 8'h83};
    rst = 1'b1; por = 1'b0; pin_n = 1'b1; wdog = 1'b0; done = 1'b1; irq = 8'h01;
    err_total = 0; comparisons = 0; acks = 0;
    for (int a = 0; a < 65536; a++) i_mem.mem[a] = 8'h9d;
    for (int a = 0; a < 9; a++) i_mem.mem[16'h0100 + a] = prog[a];
    i_mem.mem[16'hfffe] = 8'h01; i_mem.mem[16'hffff] = 8'h00;
    i_mem.mem[16'hfffc] = 8'h02; i_mem.mem[16'hfffd] = 8'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    run_program();
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      por <= (s == 0); pin_n <= (s != 1); wdog <= (s == 2); done <= (s != 3);
      repeat (4) @(posedge clk);
      #1 check({15'h0, in_rst}, 16'h1);
      @(posedge clk);
      por <= 1'b0; pin_n <= 1'b1; wdog <= 1'b0; done <= 1'b1;
      run_program();
    end
    print_verdict();
  end
  // Hang guard
  initial begin
    #10000;
    err_total++;
    print_verdict();
  end
endmodule : tb_cpu_reset_interrupt_entry
`default_nettype wire
